/* File: rtl/mv_select_pkg.sv */
// Constants, types and register map of the MV output select and limit block.
// Notes on behaviour
// RULE1 - Calculated MV is clamped between upper and lower limit before output.
// RULE2 - Manual, reset and PV-error MVs skip the limit clamp.
// RULE3 - With manual limit enabled, manual MV is clamped to the limits.
// RULE4 - Heating/cooling uses one shared limit pair on the signed MV.
// RULE5 - Reset and PV-error MVs act only when their addition setting is on.
// RULE6 - Heating/cooling fixed MV: positive drives heating, negative drives cooling magnitude.
// RULE7 - Non-position reset and error MVs default to 0.0, no output.
// RULE8 - Floating or direct-off: open drives output 1, close output 2, hold none.
// RULE9 - Position fixed reset and error selections default to hold.
// RULE10 - Close control with direct position on: fixed MV is a valve opening.
// RULE11 - Fixed MVs accept -5.0..105.0, or -105.0..105.0 for heating/cooling.
// RULE12 - Priority: manual, then reset, then PV-error, then calculated MV.
// RULE13 - Pot error, direct on: MV at least 100 opens, below 0 closes.
// RULE14 - PV-error MV on input, remote SP or (close control) pot error.
// RULE15 - Source and clamp evaluated once per control period; result registered.
package mv_select_pkg;

  // MV values are signed tenths of a percent
  localparam int MV_W = 16;
  localparam logic signed [15:0] MV_ZERO = 16'sh0000;
  localparam logic signed [15:0] MV_HUNDRED = 16'sh03E8;
  localparam logic signed [15:0] MV_STD_MIN = -16'sh0032;
  localparam logic signed [15:0] MV_HC_MIN = -16'sh041A;
  localparam logic signed [15:0] MV_MAX = 16'sh041A;

  // Reset values of the settings
  localparam logic signed [15:0] UPPER_RESET = 16'sh041A;
  localparam logic signed [15:0] LOWER_RESET = -16'sh0032;
  localparam logic signed [15:0] FIXED_RESET = 16'sh0000;

  // Byte offsets of the registers
  localparam logic [7:0] OFS_UPPER = 8'h00;
  localparam logic [7:0] OFS_LOWER = 8'h04;
  localparam logic [7:0] OFS_RESET_MV = 8'h08;
  localparam logic [7:0] OFS_FAULT_MV = 8'h0C;
  localparam logic [7:0] OFS_MANUAL_MV = 8'h10;
  localparam logic [7:0] OFS_CONFIG = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_MV_OUT = 8'h1C;

  // Config register field positions
  localparam int CFG_HEAT_COOL = 0;
  localparam int CFG_POSITION = 1;
  localparam int CFG_CLOSE_CTRL = 2;
  localparam int CFG_DIRECT_POS = 3;
  localparam int CFG_RESET_ERR_ADD = 4;
  localparam int CFG_MANUAL_LIMIT = 5;
  localparam int CFG_W = 6;

  // Status register field positions
  localparam int STS_SRC_LSB = 0;
  localparam int STS_OPEN = 4;
  localparam int STS_CLOSE = 5;

  typedef struct packed {
    logic manual_limit_en;
    logic reset_err_add;
    logic direct_pos;
    logic close_control;
    logic position_prop;
    logic heat_cool;
  } cfg_t;

  typedef struct packed {
    logic pot_error;
    logic rsp_error;
    logic input_error;
    logic reset_state;
    logic manual_mode;
  } flags_t;

  typedef enum logic [2:0] {
    src_calc = 3'b000,
    src_manual = 3'b001,
    src_reset = 3'b010,
    src_fault = 3'b011,
    src_stop = 3'b100
  } src_t;

  typedef enum logic [1:0] {
    pos_hold = 2'b00,
    pos_open = 2'b01,
    valve_close_selection = 2'b10
  } pos_cmd_t;

endpackage

/* File: rtl/mv_drive.sv */
// Output stage: turns the selected MV into heating, cooling and valve drives.
`timescale 1ns/1ps
module mv_drive #(
  parameter logic signed [15:0] DEADBAND = 16'sh000A
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Selected MV
  input wire logic load,
  input wire logic signed [15:0] mv,
  input wire mv_select_pkg::src_t src,
  input wire mv_select_pkg::cfg_t cfg,
  input wire logic pot_error,
  input wire logic signed [15:0] valve_position,
  // Drives
  output logic [15:0] heat_mv,
  output logic [15:0] cool_mv,
  output logic valve_open,
  output logic valve_close
);

  logic fixed_sel;
  logic code_mode;
  logic signed [16:0] hi_band;
  logic signed [16:0] lo_band;
  logic next_open;
  logic next_close;

  assign fixed_sel = (src == mv_select_pkg::src_reset) || (src == mv_select_pkg::src_fault);
  assign code_mode = !cfg.close_control || !cfg.direct_pos;
  assign hi_band = 17'(valve_position) + 17'(DEADBAND);
  assign lo_band = 17'(valve_position) - 17'(DEADBAND);

  always_comb begin
    next_open = 1'b0;
    next_close = 1'b0;
    if (!cfg.position_prop || src == mv_select_pkg::src_stop) begin
      next_open = 1'b0;
      next_close = 1'b0;
    end else if (fixed_sel && code_mode) begin
      next_open = (mv[1:0] == mv_select_pkg::pos_open); // RULE8 RULE9
      next_close = (mv[1:0] == mv_select_pkg::valve_close_selection); // RULE8
    end else if (pot_error && cfg.direct_pos) begin
      next_open = (mv >= mv_select_pkg::MV_HUNDRED); // RULE13
      next_close = (mv < mv_select_pkg::MV_ZERO); // RULE13
    end else if (cfg.close_control) begin
      next_open = 17'(mv) > hi_band; // RULE10
      next_close = 17'(mv) < lo_band; // RULE10
    end else begin
      next_open = mv > mv_select_pkg::MV_ZERO;
      next_close = mv < mv_select_pkg::MV_ZERO;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      heat_mv <= 16'h0000;
      cool_mv <= 16'h0000;
    end else if (load) begin
      if (cfg.position_prop || src == mv_select_pkg::src_stop) begin
        heat_mv <= 16'h0000;
        cool_mv <= 16'h0000;
      end else begin
        heat_mv <= (mv > mv_select_pkg::MV_ZERO) ? mv : 16'h0000; // RULE6 RULE7
        cool_mv <= (cfg.heat_cool && mv < mv_select_pkg::MV_ZERO) ? 16'(-mv) : 16'h0000; // RULE6
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valve_open <= 1'b0;
      valve_close <= 1'b0;
    end else if (load) begin
      valve_open <= next_open;
      valve_close <= next_close;
    end
  end

endmodule

/* File: rtl/mv_output_select_limit.sv */
// MV source selection and limiting with APB settings, top of the block.
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module mv_output_select_limit #(
  parameter logic signed [15:0] DEADBAND = 16'sh000A
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Control calculation side
  input wire logic ctrl_period,
  input wire logic signed [15:0] calc_mv,
  input wire mv_select_pkg::flags_t flags,
  input wire logic signed [15:0] valve_position,
  // Actuator side
  output logic signed [15:0] mv_out,
  output mv_select_pkg::src_t mv_source,
  output logic [15:0] heat_mv,
  output logic [15:0] cool_mv,
  output logic valve_open,
  output logic valve_close
);

  // Settings
  logic signed [15:0] mv_upper_limit;
  logic signed [15:0] mv_lower_limit;
  logic signed [15:0] fixed_mv_in_reset;
  logic signed [15:0] fixed_mv_on_pv_fault;
  logic signed [15:0] manual_mv;
  mv_select_pkg::cfg_t cfg;

  logic access;
  logic wr_en;
  logic mapped;
  logic [31:0] rd_word;
  logic signed [15:0] wr_mv;
  logic signed [15:0] fixed_min;
  logic pv_fault;
  logic signed [15:0] next_mv;
  mv_select_pkg::src_t next_src;

  function automatic logic signed [15:0] clamp(
    input logic signed [15:0] v,
    input logic signed [15:0] lo,
    input logic signed [15:0] hi
  );
    logic signed [15:0] r;
    r = v;
    if (v > hi) begin
      r = hi;
    end
    if (v < lo) begin
      r = lo;
    end
    return r;
  endfunction

  function automatic logic [31:0] sext(input logic signed [15:0] v);
    return {{16{v[15]}}, v};
  endfunction

  assign access = psel && penable;
  assign wr_en = access && pready && pwrite && mapped;
  assign wr_mv = pwdata[15:0];
  assign fixed_min = cfg.heat_cool ? mv_select_pkg::MV_HC_MIN : mv_select_pkg::MV_STD_MIN;

  // Address decode and read mux
  always_comb begin
    mapped = 1'b1;
    rd_word = 32'h0000_0000;
    case (paddr)
      mv_select_pkg::OFS_UPPER: begin
        rd_word = sext(mv_upper_limit);
      end
      mv_select_pkg::OFS_LOWER: begin
        rd_word = sext(mv_lower_limit);
      end
      mv_select_pkg::OFS_RESET_MV: begin
        rd_word = sext(fixed_mv_in_reset);
      end
      mv_select_pkg::OFS_FAULT_MV: begin
        rd_word = sext(fixed_mv_on_pv_fault);
      end
      mv_select_pkg::OFS_MANUAL_MV: begin
        rd_word = sext(manual_mv);
      end
      mv_select_pkg::OFS_CONFIG: begin
        rd_word = {26'h0, cfg};
      end
      mv_select_pkg::OFS_STATUS: begin
        rd_word = {26'h0, valve_close, valve_open, 1'b0, mv_source};
      end
      mv_select_pkg::OFS_MV_OUT: begin
        rd_word = sext(mv_out);
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // One wait state: pready rises on the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (access && !pready) begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h0000_0000 : rd_word;
      pslverr <= !mapped;
    end else begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // Limit pair, shared by heating and cooling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mv_upper_limit <= mv_select_pkg::UPPER_RESET;
      mv_lower_limit <= mv_select_pkg::LOWER_RESET;
    end else if (wr_en) begin
      if (paddr == mv_select_pkg::OFS_UPPER) begin
        mv_upper_limit <= wr_mv; // RULE4
      end
      if (paddr == mv_select_pkg::OFS_LOWER) begin
        mv_lower_limit <= wr_mv; // RULE4
      end
    end
  end

  // Fixed MVs saturate to the range of the current control mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fixed_mv_in_reset <= mv_select_pkg::FIXED_RESET; // RULE7 RULE9
      fixed_mv_on_pv_fault <= mv_select_pkg::FIXED_RESET; // RULE7 RULE9
    end else if (wr_en) begin
      if (paddr == mv_select_pkg::OFS_RESET_MV) begin
        fixed_mv_in_reset <= clamp(wr_mv, fixed_min, mv_select_pkg::MV_MAX); // RULE11
      end
      if (paddr == mv_select_pkg::OFS_FAULT_MV) begin
        fixed_mv_on_pv_fault <= clamp(wr_mv, fixed_min, mv_select_pkg::MV_MAX); // RULE11
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      manual_mv <= mv_select_pkg::MV_ZERO;
    end else if (wr_en && paddr == mv_select_pkg::OFS_MANUAL_MV) begin
      manual_mv <= wr_mv;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= '0;
    end else if (wr_en && paddr == mv_select_pkg::OFS_CONFIG) begin
      cfg <= pwdata[mv_select_pkg::CFG_W-1:0];
    end
  end

  // Pot error counts only in close control
  assign pv_fault = flags.input_error || flags.rsp_error
                    || (flags.pot_error && cfg.close_control); // RULE14

  // Source priority
  always_comb begin
    next_src = mv_select_pkg::src_calc;
    next_mv = clamp(calc_mv, mv_lower_limit, mv_upper_limit); // RULE1 RULE4
    if (flags.manual_mode) begin // RULE12
      next_src = mv_select_pkg::src_manual;
      if (cfg.manual_limit_en) begin
        next_mv = clamp(manual_mv, mv_lower_limit, mv_upper_limit); // RULE3
      end else begin
        next_mv = manual_mv; // RULE2
      end
    end else if (flags.reset_state) begin // RULE12
      if (cfg.reset_err_add) begin // RULE5
        next_src = mv_select_pkg::src_reset;
        next_mv = fixed_mv_in_reset; // RULE2
      end else begin
        next_src = mv_select_pkg::src_stop;
        next_mv = mv_select_pkg::MV_ZERO;
      end
    end else if (pv_fault && cfg.reset_err_add) begin // RULE5 RULE12 RULE14
      next_src = mv_select_pkg::src_fault;
      next_mv = fixed_mv_on_pv_fault; // RULE2
    end
  end

  // Result registered once per control period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mv_out <= mv_select_pkg::MV_ZERO;
      mv_source <= mv_select_pkg::src_stop;
    end else if (ctrl_period) begin
      mv_out <= next_mv; // RULE15
      mv_source <= next_src; // RULE15
    end
  end

  mv_drive #(
    .DEADBAND(DEADBAND)
  ) u_drive (
    .pclk(pclk),
    .presetn(presetn),
    .load(ctrl_period), // RULE15
    .mv(next_mv),
    .src(next_src),
    .cfg(cfg),
    .pot_error(flags.pot_error),
    .valve_position(valve_position),
    .heat_mv(heat_mv),
    .cool_mv(cool_mv),
    .valve_open(valve_open),
    .valve_close(valve_close)
  );

endmodule

/* File: testbench/mv_select_props.sv */
// Port-level assertions for the MV select and limit block.
`timescale 1ns/1ps
module mv_select_props (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Control side
  input wire logic ctrl_period,
  input wire mv_select_pkg::flags_t flags,
  // Actuator side
  input wire logic signed [15:0] mv_out,
  input wire mv_select_pkg::src_t mv_source,
  input wire logic [15:0] heat_mv,
  input wire logic [15:0] cool_mv,
  input wire logic valve_open,
  input wire logic valve_close
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_one_wait;
    !pready ##1 pready;
  endsequence
  sequence s_strobe_idle;
    ctrl_period && flags.manual_mode == 1'b0 && flags.reset_state == 1'b0;
  endsequence
  property p_wait;
    s_setup |=> s_one_wait;
  endproperty
  property p_rdz;
    !pready |-> prdata == 32'h00000000;
  endproperty
  property p_err;
    pslverr |-> pready;
  endproperty
  property p_hold;
    !ctrl_period |=> $stable(mv_out) && $stable(mv_source) && $stable(heat_mv)
      && $stable(cool_mv) && $stable(valve_open) && $stable(valve_close);
  endproperty
  property p_man;
    ctrl_period && flags.manual_mode |=> mv_source == mv_select_pkg::src_manual;
  endproperty
  property p_rst;
    ctrl_period && !flags.manual_mode && flags.reset_state
      |=> mv_source inside {mv_select_pkg::src_reset, mv_select_pkg::src_stop};
  endproperty
  property p_flt;
    s_strobe_idle ##0 (flags.input_error || flags.rsp_error)
      |=> mv_source inside {mv_select_pkg::src_fault, mv_select_pkg::src_calc};
  endproperty
  property p_calc;
    s_strobe_idle ##0 flags == 5'h00 |=> mv_source == mv_select_pkg::src_calc;
  endproperty
  property p_valve;
    !(valve_open && valve_close);
  endproperty
  property p_hc;
    !(heat_mv != 16'h0000 && cool_mv != 16'h0000);
  endproperty
  property p_stop;
    mv_source == mv_select_pkg::src_stop |-> mv_out == 16'sh0000 && heat_mv == 16'h0000;
  endproperty
  a_wait: assert property (p_wait) else $error("pready not after one wait state");
  a_rdz: assert property (p_rdz) else $error("prdata not zero outside pready");
  a_err: assert property (p_err) else $error("pslverr without pready");
  a_hold: assert property (p_hold) else $error("output moved between strobes");
  a_man: assert property (p_man) else $error("manual MV not selected");
  a_rst: assert property (p_rst) else $error("reset MV not selected");
  a_flt: assert property (p_flt) else $error("fault MV not selected");
  a_calc: assert property (p_calc) else $error("calculated MV not selected");
  a_valve: assert property (p_valve) else $error("open and close both on");
  a_hc: assert property (p_hc) else $error("heating and cooling both on");
  a_stop: assert property (p_stop) else $error("stop source drives output");
endmodule
bind mv_output_select_limit mv_select_props mv_select_props_i (.pclk, .presetn, .psel,
  .penable, .prdata, .pready, .pslverr, .ctrl_period, .flags, .mv_out, .mv_source,
  .heat_mv, .cool_mv, .valve_open, .valve_close);

/* File: testbench/valve_model.sv */
// Behavioural motorized valve with its opening potentiometer.
`timescale 1ns/1ps
module valve_model #(
  parameter logic signed [15:0] START = 16'sh01F4,
  parameter logic signed [15:0] STEP = 16'sh0064
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Drives
  input wire logic ctrl_period,
  input wire logic valve_open,
  input wire logic valve_close,
  // Potentiometer
  output logic signed [15:0] valve_position
);
  // One step per period, kept inside 0 to 100.0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valve_position <= START;
    end else if (ctrl_period && valve_open && !valve_close) begin
      valve_position <= (valve_position >= 16'sh03E8 - STEP) ? 16'sh03E8 : valve_position + STEP;
    end else if (ctrl_period && valve_close && !valve_open) begin
      valve_position <= (valve_position <= STEP) ? 16'sh0000 : valve_position - STEP;
    end
  end
endmodule

/* File: testbench/tb_top.sv */
// Self-checking bench for the MV select and limit block.
`timescale 1ns/1ps
module tb_top;
  localparam logic [2:0] SC = 3'h0, SM = 3'h1, SR = 3'h2, SF = 3'h3, SS = 3'h4;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic ctrl_period = 1'b0, pready, pslverr, valve_open, valve_close, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic signed [15:0] calc_mv = 16'sh0000, valve_position, mv_out;
  logic [15:0] heat_mv, cool_mv;
  mv_select_pkg::flags_t flags = 5'h00;
  mv_select_pkg::src_t mv_source;
  int mismatches = 0, tests_run = 0;
  always #5 pclk = ~pclk;
  mv_output_select_limit mv_output_select_limit_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ctrl_period(ctrl_period),
    .calc_mv(calc_mv), .flags(flags), .valve_position(valve_position), .mv_out(mv_out),
    .mv_source(mv_source), .heat_mv(heat_mv), .cool_mv(cool_mv), .valve_open(valve_open),
    .valve_close(valve_close));
  valve_model valve_model_i (.pclk(pclk), .presetn(presetn), .ctrl_period(ctrl_period),
    .valve_open(valve_open), .valve_close(valve_close), .valve_position(valve_position));
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic is_wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= is_wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // Sampled at the rising edge, before the slave updates its outputs
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      $display("ERROR %0t: no pready", $time);
      tally_and_finish();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(rd, exp);
  endtask
  task automatic step(input logic signed [15:0] c, input logic [4:0] f);
    @(posedge pclk);
    ctrl_period <= 1'b1;
    calc_mv <= c;
    flags <= f;
    @(posedge pclk);
    ctrl_period <= 1'b0;
    #1;
  endtask
  task automatic ex(input logic signed [15:0] m, input logic [2:0] s, input logic [15:0] h,
                    input logic [15:0] c, input logic [1:0] oc);
    chk({mv_out, heat_mv}, {m, h});
    chk({cool_mv, 11'h000, mv_source, valve_open, valve_close}, {c, 11'h000, s, oc});
  endtask
  task automatic pot(input logic [7:0] a, input logic [31:0] v, input logic [4:0] f,
                     input logic [2:0] s, input logic [1:0] oc);
    wr(a, v);
    step(16'sh0000, f);
    chk(32'({mv_source, valve_open, valve_close}), 32'({s, oc}));
  endtask
  initial begin
    int n;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    ex(16'sh0000, SS, 16'h0000, 16'h0000, 2'b00);
    rc(8'h00, 32'h0000041A);
    rc(8'h04, 32'hFFFFFFCE);
    rc(8'h14, 32'h00000000);
    rc(8'h18, 32'h00000004);
    wr(8'h1C, 32'h00000005);
    rc(8'h1C, 32'h00000000);
    apb(1'b0, 8'h20, 32'h00000000);
    chk({rd[30:0], err}, 32'h00000001);
    $display("test reset values done");
    wr(8'h00, 32'h00000320);
    wr(8'h04, 32'h00000064);
    step(16'sh0384, 5'h00);
    ex(16'sh0320, SC, 16'h0320, 16'h0000, 2'b00);
    step(16'sh0032, 5'h00);
    ex(16'sh0064, SC, 16'h0064, 16'h0000, 2'b00);
    rc(8'h1C, 32'h00000064);
    wr(8'h10, 32'h000003B6);
    step(16'sh0384, 5'h01);
    ex(16'sh03B6, SM, 16'h03B6, 16'h0000, 2'b00);
    wr(8'h14, 32'h00000020);
    step(16'sh0384, 5'h01);
    ex(16'sh0320, SM, 16'h0320, 16'h0000, 2'b00);
    $display("test limits done");
    wr(8'h14, 32'h00000000);
    step(16'sh012C, 5'h02);
    ex(16'sh0000, SS, 16'h0000, 16'h0000, 2'b00);
    step(16'sh012C, 5'h04);
    ex(16'sh012C, SC, 16'h012C, 16'h0000, 2'b00);
    wr(8'h14, 32'h00000010);
    step(16'sh012C, 5'h02);
    ex(16'sh0000, SR, 16'h0000, 16'h0000, 2'b00);
    wr(8'h08, 32'h000003E8);
    wr(8'h0C, 32'h00000028);
    step(16'sh012C, 5'h02);
    ex(16'sh03E8, SR, 16'h03E8, 16'h0000, 2'b00);
    step(16'sh012C, 5'h03);
    ex(16'sh03B6, SM, 16'h03B6, 16'h0000, 2'b00);
    step(16'sh012C, 5'h06);
    ex(16'sh03E8, SR, 16'h03E8, 16'h0000, 2'b00);
    step(16'sh012C, 5'h04);
    ex(16'sh0028, SF, 16'h0028, 16'h0000, 2'b00);
    step(16'sh012C, 5'h08);
    ex(16'sh0028, SF, 16'h0028, 16'h0000, 2'b00);
    wr(8'h0C, 32'h000007D0);
    rc(8'h0C, 32'h0000041A);
    wr(8'h0C, 32'hFFFFFF38);
    rc(8'h0C, 32'hFFFFFFCE);
    $display("test source priority done");
    wr(8'h14, 32'h00000011);
    wr(8'h04, 32'hFFFFFED4);
    step(16'shFE0C, 5'h00);
    ex(16'shFED4, SC, 16'h0000, 16'h012C, 2'b00);
    wr(8'h0C, 32'hFFFFF830);
    rc(8'h0C, 32'hFFFFFBE6);
    wr(8'h0C, 32'hFFFFFE70);
    step(16'sh0000, 5'h04);
    ex(16'shFE70, SF, 16'h0000, 16'h0190, 2'b00);
    wr(8'h08, 32'h00000258);
    step(16'sh0000, 5'h02);
    ex(16'sh0258, SR, 16'h0258, 16'h0000, 2'b00);
    $display("test heating cooling done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    ex(16'sh0000, SS, 16'h0000, 16'h0000, 2'b00);
    rc(8'h0C, 32'h00000000);
    wr(8'h14, 32'h00000012);
    step(16'sh0000, 5'h02);
    chk(32'({valve_open, valve_close}), 32'h00000000);
    for (int i = 1; i < 4; i++) begin
      wr(8'h08, 32'(i));
      step(16'sh0000, 5'h02);
      chk(32'({valve_open, valve_close}), (i == 1) ? 32'h2 : (i == 2) ? 32'h1 : 32'h0);
    end
    wr(8'h08, 32'h00000000);
    wr(8'h14, 32'h0000001E);
    step(16'sh0000, 5'h02);
    ex(16'sh0000, SR, 16'h0000, 16'h0000, 2'b01);
    for (n = 0; n < 12 && valve_close === 1'b1; n++) step(16'sh0000, 5'h02);
    chk({valve_position, 14'h0000, valve_open, valve_close}, 32'h00000000);
    pot(8'h08, 32'h000003E8, 5'h12, SR, 2'b10);
    pot(8'h08, 32'hFFFFFFF6, 5'h12, SR, 2'b01);
    pot(8'h08, 32'h000001F4, 5'h12, SR, 2'b00);
    pot(8'h0C, 32'h000003E8, 5'h10, SF, 2'b10);
    $display("test position outputs done");
    tally_and_finish();
  end
endmodule
